// ---- common/srbf_pkg.sv ----
// Constants shared by both ends of the receive buffer FIFO link.
// Assumes one 40 MHz system clock and 32-bit register words.
package srbf_pkg;
   // ==========================================================
   // Register map
   localparam int          ADDR_W    = 8;
   localparam int          DATA_W    = 32;
   localparam logic [7:0]  CTRL_OFS  = 8'h00;
   localparam logic [7:0]  STAT_OFS  = 8'h04;
   localparam logic [7:0]  DATA_OFS  = 8'h08;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0001_FFFF;
   // ==========================================================
   // Field layout
   localparam int          ENA_BIT   = 16;
   localparam int          THR_LSB   = 8;
   localparam int          CNT_LSB   = 0;
   localparam int          LVL_LSB   = 0;
   localparam int          FLD_W     = 8;
   localparam logic [7:0]  THR_MAX   = 8'h40;
   localparam logic [7:0]  CNT_MAX   = 8'h01;
   localparam logic [7:0]  PEND_MAX  = 8'hFF;
   // ==========================================================
   // Storage
   localparam int          DEPTH     = 64;
endpackage

// ---- common/srbf_if.sv ----
// Link between the host end (APB master) and the FIFO end (APB slave).
// Assumes both ends share CLK_SYS_I; the bench joins them.
`timescale 1ns/1ps
interface srbf_if;
   logic                              psel;
   logic                              penable;
   logic                              pwrite;
   logic [srbf_pkg::ADDR_W-1:0]       paddr;
   logic [srbf_pkg::DATA_W-1:0]       pwdata;
   logic [srbf_pkg::DATA_W-1:0]       prdata;
   logic                              pready;
   logic                              pslverr;
   logic                              rx_dma_event;

   modport dev
   (
      input  psel, penable, pwrite, paddr, pwdata,
      output prdata, pready, pslverr, rx_dma_event
   );
   modport host
   (
      output psel, penable, pwrite, paddr, pwdata,
      input  prdata, pready, pslverr, rx_dma_event
   );
endinterface

// ---- design/srbf_dev.sv ----
// Receive buffer FIFO end: storage, register slave, serial port pull.
// Assumes serial port inputs are synchronous to CLK_SYS_I.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// ==========================================================
// Storage with valid/ready on both sides
module srbf_fifo
#(
   parameter int WIDTH = srbf_pkg::DATA_W,
   parameter int DEPTH = srbf_pkg::DEPTH
)
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       flush_i,
   input  wire logic                       in_valid_i,
   output      logic                       in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   output      logic                       out_valid_o,
   input  wire logic                       out_ready_i,
   output      logic [WIDTH-1:0]           out_data_o,
   output      logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    cnt_r;
   logic             push;
   logic             pop;

   // RULE9: no push when full
   assign in_ready_o  = (cnt_r != CW'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign push        = in_valid_i & in_ready_o & ~flush_i;
   assign pop         = out_valid_o & out_ready_i & ~flush_i;
   assign out_data_o  = mem[rd_ptr_r];
   assign level_o     = cnt_r;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   // Depth is assumed a power of two so pointers wrap naturally
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end
      // RULE1: flush pointers
      else if (flush_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule

// What this block does
// RULE1: Enable low flushes FIFO, level reads zero
// RULE2: Software enables FIFO before serial port runs
// RULE3: Event while level reaches event threshold
// RULE4: Threshold 0..40h words; above is reserved
// RULE5: Each port event pulls per-transfer word count
// RULE6: Per-transfer count 0 or 1; rest reserved
// RULE7: Fields programmed before enable is set
// RULE8: Status level reports exact stored words
// RULE9: 64-word storage; stall pulls while full
// RULE10: Data read pops oldest; event follows level
module srbf_dev
#(
   parameter int DEPTH = srbf_pkg::DEPTH
)
(
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        RST_N_I,
   srbf_if.dev                              BUS,
   input  wire logic                        SP_EVT_I,
   input  wire logic [srbf_pkg::DATA_W-1:0] SP_DATA_I,
   output      logic                        SP_RD_O
);
   localparam int CW = $clog2(DEPTH+1);

   logic [31:0]                 ctrl_r;
   logic [31:0]                 prdata_r;
   logic                        err_r;
   logic                        rd_ok_r;
   logic                        event_r;
   logic [7:0]                  pend_r;
   logic                        enable;
   logic [7:0]                  thr;
   logic [7:0]                  per_xfer;
   logic                        setup;
   logic                        wr_acc;
   logic                        rd_acc;
   logic                        f_in_valid;
   logic                        f_in_ready;
   logic                        f_out_valid;
   logic                        f_out_ready;
   logic [srbf_pkg::DATA_W-1:0] f_out_data;
   logic [CW-1:0]               level;
   logic [7:0]                  level8;

   assign enable   = ctrl_r[srbf_pkg::ENA_BIT];
   assign thr      = ctrl_r[srbf_pkg::THR_LSB +: srbf_pkg::FLD_W];
   assign per_xfer = ctrl_r[srbf_pkg::CNT_LSB +: srbf_pkg::FLD_W];
   assign level8   = 8'(level);
   assign setup    = BUS.psel & ~BUS.penable;
   assign wr_acc   = BUS.psel & BUS.penable & BUS.pwrite;
   assign rd_acc   = BUS.psel & BUS.penable & ~BUS.pwrite;

   // ==========================================================
   // APB slave, zero wait states
   assign BUS.pready       = 1'b1;
   assign BUS.prdata       = prdata_r;
   assign BUS.pslverr      = err_r & BUS.psel & BUS.penable;
   assign BUS.rx_dma_event = event_r;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ctrl_r <= srbf_pkg::CTRL_RST;
      end
      else if (wr_acc && BUS.paddr == srbf_pkg::CTRL_OFS)
      begin
         ctrl_r <= BUS.pwdata & srbf_pkg::CTRL_MASK;
      end
   end

   // Read data and error are fixed in setup so a push during the
   // access cycle cannot change the word being returned
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
         rd_ok_r  <= 1'b0;
      end
      else if (setup)
      begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
         rd_ok_r  <= 1'b0;
         unique case (BUS.paddr)
            srbf_pkg::CTRL_OFS:
            begin
               prdata_r <= ctrl_r;
            end
            srbf_pkg::STAT_OFS:
            begin
               // RULE8: exact level
               prdata_r[srbf_pkg::LVL_LSB +: srbf_pkg::FLD_W] <= level8;
               err_r <= BUS.pwrite;
            end
            srbf_pkg::DATA_OFS:
            begin
               // RULE10: oldest word
               // RULE1: flushed words never leak
               if (f_out_valid && !BUS.pwrite)
               begin
                  prdata_r <= f_out_data;
               end
               rd_ok_r  <= f_out_valid & ~BUS.pwrite;
               err_r    <= BUS.pwrite | ~f_out_valid;
            end
            default:
            begin
               err_r <= 1'b1;
            end
         endcase
      end
   end

   // RULE10: pop on data read
   assign f_out_ready = rd_acc & rd_ok_r & (BUS.paddr == srbf_pkg::DATA_OFS);

   // ==========================================================
   // Serial port pull
   // RULE5: count owed words
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pend_r <= 8'h00;
      end
      else if (!enable)
      begin
         pend_r <= 8'h00;
      end
      else if (SP_EVT_I && per_xfer != 8'h00 && !SP_RD_O && pend_r != srbf_pkg::PEND_MAX)
      begin
         pend_r <= pend_r + 8'h01;
      end
      else if (!(SP_EVT_I && per_xfer != 8'h00) && SP_RD_O)
      begin
         pend_r <= pend_r - 8'h01;
      end
   end

   // RULE9: stall while full
   assign f_in_valid = enable & (pend_r != 8'h00);
   assign SP_RD_O    = f_in_valid & f_in_ready;

   // ==========================================================
   // Receive event, one cycle behind the level
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         event_r <= 1'b0;
      end
      else
      begin
         // RULE3: level at threshold
         event_r <= enable & (level8 >= thr);
      end
   end

   srbf_fifo
   #(
      .WIDTH (srbf_pkg::DATA_W),
      .DEPTH (DEPTH)
   )
   u_fifo
   (
      .clk_i       (CLK_SYS_I),
      .rst_n_i     (RST_N_I),
      // RULE1: disable flushes
      .flush_i     (~enable),
      .in_valid_i  (f_in_valid),
      .in_ready_o  (f_in_ready),
      .in_data_i   (SP_DATA_I),
      .out_valid_o (f_out_valid),
      .out_ready_i (f_out_ready),
      .out_data_o  (f_out_data),
      .level_o     (level)
   );
endmodule

// ---- design/srbf_host.sv ----
// Host end: APB master toward the FIFO end, with software guards.
// Assumes commands are synchronous to CLK_SYS_I.
`timescale 1ns/1ps
module srbf_host
(
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        RST_N_I,
   srbf_if.host                             BUS,
   input  wire logic                        CMD_VALID_I,
   input  wire logic                        CMD_WRITE_I,
   input  wire logic [srbf_pkg::ADDR_W-1:0] CMD_ADDR_I,
   input  wire logic [srbf_pkg::DATA_W-1:0] CMD_WDATA_I,
   output      logic                        CMD_READY_O,
   output      logic                        RSP_VALID_O,
   output      logic [srbf_pkg::DATA_W-1:0] RSP_RDATA_O,
   output      logic                        RSP_ERR_O,
   input  wire logic                        SP_START_I,
   output      logic                        SP_RUN_O,
   output      logic                        RX_DMA_EVENT_O
);
   typedef enum logic [1:0] {SRBF_IDLE, SRBF_SETUP, SRBF_ACCESS} srbf_state_t;

   srbf_state_t state_r;
   logic [31:0] shadow_r;
   logic        psel_r;
   logic        penable_r;
   logic        pwrite_r;
   logic [7:0]  paddr_r;
   logic [31:0] pwdata_r;
   logic        rsp_valid_r;
   logic [31:0] rsp_rdata_r;
   logic        rsp_err_r;
   logic        run_r;
   logic        event_r;
   logic        refuse;
   logic        new_ena;
   logic [15:0] new_fields;

   assign new_ena    = CMD_WDATA_I[srbf_pkg::ENA_BIT];
   assign new_fields = CMD_WDATA_I[15:0];

   // ==========================================================
   // Guards on control writes
   always_comb
   begin
      refuse = 1'b0;
      if (CMD_WRITE_I && CMD_ADDR_I == srbf_pkg::CTRL_OFS)
      begin
         // RULE4: reserved threshold
         if (CMD_WDATA_I[srbf_pkg::THR_LSB +: srbf_pkg::FLD_W] > srbf_pkg::THR_MAX)
         begin
            refuse = 1'b1;
         end
         // RULE6: reserved count
         if (CMD_WDATA_I[srbf_pkg::CNT_LSB +: srbf_pkg::FLD_W] > srbf_pkg::CNT_MAX)
         begin
            refuse = 1'b1;
         end
         // RULE7: fields before enable
         if (new_ena && new_fields != shadow_r[15:0])
         begin
            refuse = 1'b1;
         end
         // RULE2: enable before port runs
         if (new_ena && !shadow_r[srbf_pkg::ENA_BIT] && run_r)
         begin
            refuse = 1'b1;
         end
      end
   end

   assign CMD_READY_O    = (state_r == SRBF_IDLE);
   assign BUS.psel       = psel_r;
   assign BUS.penable    = penable_r;
   assign BUS.pwrite     = pwrite_r;
   assign BUS.paddr      = paddr_r;
   assign BUS.pwdata     = pwdata_r;
   assign RSP_VALID_O    = rsp_valid_r;
   assign RSP_RDATA_O    = rsp_rdata_r;
   assign RSP_ERR_O      = rsp_err_r;
   assign SP_RUN_O       = run_r;
   assign RX_DMA_EVENT_O = event_r;

   // ==========================================================
   // APB master sequence
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_r     <= SRBF_IDLE;
         psel_r      <= 1'b0;
         penable_r   <= 1'b0;
         pwrite_r    <= 1'b0;
         paddr_r     <= 8'h00;
         pwdata_r    <= 32'h0000_0000;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 32'h0000_0000;
         rsp_err_r   <= 1'b0;
      end
      else
      begin
         rsp_valid_r <= 1'b0;
         unique case (state_r)
            SRBF_IDLE:
            begin
               if (CMD_VALID_I && refuse)
               begin
                  rsp_valid_r <= 1'b1;
                  rsp_rdata_r <= 32'h0000_0000;
                  rsp_err_r   <= 1'b1;
               end
               else if (CMD_VALID_I)
               begin
                  psel_r   <= 1'b1;
                  pwrite_r <= CMD_WRITE_I;
                  paddr_r  <= CMD_ADDR_I;
                  pwdata_r <= CMD_WDATA_I;
                  state_r  <= SRBF_SETUP;
               end
            end
            SRBF_SETUP:
            begin
               penable_r <= 1'b1;
               state_r   <= SRBF_ACCESS;
            end
            SRBF_ACCESS:
            begin
               if (BUS.pready)
               begin
                  psel_r      <= 1'b0;
                  penable_r   <= 1'b0;
                  rsp_valid_r <= 1'b1;
                  rsp_rdata_r <= pwrite_r ? 32'h0000_0000 : BUS.prdata;
                  rsp_err_r   <= BUS.pslverr;
                  state_r     <= SRBF_IDLE;
               end
            end
         endcase
      end
   end

   // Shadow follows only control writes the slave accepted
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         shadow_r <= srbf_pkg::CTRL_RST;
      end
      else if (state_r == SRBF_ACCESS && BUS.pready && !BUS.pslverr && pwrite_r
               && paddr_r == srbf_pkg::CTRL_OFS)
      begin
         shadow_r <= pwdata_r & srbf_pkg::CTRL_MASK;
      end
   end

   // Serial port release is one-way until reset
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         run_r   <= 1'b0;
         event_r <= 1'b0;
      end
      else
      begin
         run_r   <= run_r | SP_START_I;
         event_r <= BUS.rx_dma_event;
      end
   end
endmodule

// ---- sim/srbf_monitor.sv ----
// Concurrent checks on the link between the host end and the FIFO end.
// Assumes one srbf_if instance, clocked by CLK_SYS_I.
`timescale 1ns/1ps
module srbf_monitor
(
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        RST_N_I,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [srbf_pkg::ADDR_W-1:0] paddr,
   input  wire logic [srbf_pkg::DATA_W-1:0] pwdata,
   input  wire logic [srbf_pkg::DATA_W-1:0] prdata,
   input  wire logic                        pready,
   input  wire logic                        pslverr,
   input  wire logic                        rx_dma_event
);
   logic        acc;
   logic        wr_ctl;
   logic        rd_st;
   logic        en;
   logic        stb;
   logic [31:0] ctl_r;
   logic [1:0]  age_r;
   assign acc    = psel && penable && pready;
   assign wr_ctl = acc && pwrite && paddr == srbf_pkg::CTRL_OFS && !pslverr;
   assign rd_st  = acc && !pwrite && paddr == srbf_pkg::STAT_OFS;
   assign en     = ctl_r[srbf_pkg::ENA_BIT];
   assign stb    = age_r == 2'h3;
   // ==========================================================
   // Control mirror; age lets the registered event settle first
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ctl_r <= srbf_pkg::CTRL_RST;
      else if (wr_ctl)
         ctl_r <= pwdata & srbf_pkg::CTRL_MASK;
   end
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         age_r <= 2'h3;
      else if (wr_ctl)
         age_r <= 2'h0;
      else if (!stb)
         age_r <= age_r + 2'h1;
   end
   // ==========================================================
   // Assertions
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   a_evt_dis_low: assert property (!en && stb |-> !rx_dma_event)
      else $error("event high while disabled");
   a_evt_thr_zero: assert property (en && ctl_r[15:8] == 8'h00 && stb |-> rx_dma_event)
      else $error("event low with zero threshold");
   a_evt_needs_en: assert property ($rose(rx_dma_event) |-> $past(en))
      else $error("event rose while disabled");
   a_stat_dis_zero: assert property (rd_st && !en && stb |-> prdata == 32'h0)
      else $error("level not zero while disabled");
   a_stat_level_range: assert property (rd_st |-> prdata[31:8] == 24'h0 && prdata[7:0] <= 8'h40)
      else $error("status level out of range");
   a_data_dis_err: assert property (acc && !pwrite && paddr == srbf_pkg::DATA_OFS && !en && stb
      |-> pslverr)
      else $error("data read while flushed not refused");
   a_ctl_readback: assert property (acc && !pwrite && paddr == srbf_pkg::CTRL_OFS
      |-> prdata == ctl_r)
      else $error("control readback differs");
   a_thr_legal: assert property (wr_ctl |-> pwdata[15:8] <= srbf_pkg::THR_MAX)
      else $error("reserved threshold written");
   a_cnt_legal: assert property (wr_ctl |-> pwdata[7:0] <= srbf_pkg::CNT_MAX)
      else $error("reserved count written");
   a_en_after_fields: assert property (wr_ctl && pwdata[16] && !en
      |-> pwdata[15:0] == ctl_r[15:0])
      else $error("enable set with new fields");
   c_enable: cover property (wr_ctl && pwdata[16]);
   c_full: cover property (rd_st && prdata[7:0] == 8'h40);
   c_refused: cover property (acc && pslverr);
endmodule

// ---- sim/serial_receive_buffer_fifo_tb_top.sv ----
// Bench joining the host end and the FIFO end over one link.
// Assumes one 40 MHz clock; commands and serial words come from here.
`timescale 1ns/1ps
module serial_receive_buffer_fifo_tb_top;
   logic        clk;
   logic        rst_n;
   logic        c_vld;
   logic        c_wr;
   logic [7:0]  c_adr;
   logic [31:0] c_wd;
   logic        c_rdy;
   logic        r_vld;
   logic [31:0] r_rd;
   logic        r_err;
   logic        sp_start;
   logic        sp_run;
   logic        evt;
   logic        sp_evt;
   logic        sp_rd;
   logic [31:0] sp_cnt;
   int          err_total;
   int          samples_checked;
   localparam logic [31:0] B = 32'hA500_0000;
   srbf_if bus ();
   srbf_dev i_srbf_dev (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BUS(bus), .SP_EVT_I(sp_evt),
      .SP_DATA_I(B + sp_cnt), .SP_RD_O(sp_rd));
   srbf_host i_srbf_host (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BUS(bus), .CMD_VALID_I(c_vld),
      .CMD_WRITE_I(c_wr), .CMD_ADDR_I(c_adr), .CMD_WDATA_I(c_wd), .CMD_READY_O(c_rdy),
      .RSP_VALID_O(r_vld), .RSP_RDATA_O(r_rd), .RSP_ERR_O(r_err), .SP_START_I(sp_start),
      .SP_RUN_O(sp_run), .RX_DMA_EVENT_O(evt));
   srbf_monitor i_srbf_monitor (.CLK_SYS_I(clk), .RST_N_I(rst_n), .psel(bus.psel),
      .penable(bus.penable), .pwrite(bus.pwrite), .paddr(bus.paddr), .pwdata(bus.pwdata),
      .prdata(bus.prdata), .pready(bus.pready), .pslverr(bus.pslverr),
      .rx_dma_event(bus.rx_dma_event));
   // ==========================================================
   // Clock and serial word source
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (sp_rd === 1'b1)
         sp_cnt <= sp_cnt + 32'h1;
   end
   // ==========================================================
   // Tasks
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("Error at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One command through the host port; waits are bounded
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic ee, input logic [31:0] ed);
      int n;
      @(posedge clk);
      c_vld <= 1'b1;
      c_wr  <= w;
      c_adr <= a;
      c_wd  <= d;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (c_rdy !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_total++;
         end_of_test();
      end
      @(posedge clk);
      c_vld <= 1'b0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (r_vld !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         err_total++;
         end_of_test();
      end
      chk({31'h0, r_err}, {31'h0, ee});
      if (!w)
         chk(r_rd, ed);
   endtask
   task automatic push(input int n);
      repeat (n)
      begin
         @(posedge clk);
         sp_evt <= 1'b1;
      end
      @(posedge clk);
      sp_evt <= 1'b0;
      tick(4);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      c_vld = 1'b0;
      c_wr = 1'b0;
      c_adr = 8'h00;
      c_wd = 32'h0;
      sp_start = 1'b0;
      sp_evt = 1'b0;
      sp_cnt = 32'h0;
      err_total = 0;
      samples_checked = 0;
      tick(10);
      rst_n <= 1'b1;
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h0);
      acc(1'b0, 8'h00, 32'h0, 1'b0, 32'h0);
      acc(1'b1, 8'h00, 32'h0000_4100, 1'b1, 32'h0);
      acc(1'b1, 8'h00, 32'h0000_0002, 1'b1, 32'h0);
      acc(1'b1, 8'h00, 32'h0001_4001, 1'b1, 32'h0);
      acc(1'b1, 8'h00, 32'h0001_0000, 1'b0, 32'h0);
      push(1);
      @(negedge clk);
      chk(evt, 1'b1);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h0);
      acc(1'b1, 8'h00, 32'h0000_4001, 1'b0, 32'h0);
      acc(1'b1, 8'h00, 32'h0001_4001, 1'b0, 32'h0);
      acc(1'b0, 8'h00, 32'h0, 1'b0, 32'h0001_4001);
      @(posedge clk);
      sp_start <= 1'b1;
      @(posedge clk);
      sp_start <= 1'b0;
      @(negedge clk);
      chk({31'h0, sp_run}, 32'h1);
      push(3);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h3);
      chk(sp_cnt, 32'h3);
      chk(evt, 1'b0);
      acc(1'b0, 8'h08, 32'h0, 1'b0, B);
      acc(1'b0, 8'h08, 32'h0, 1'b0, B + 32'h1);
      push(63);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h40);
      chk(evt, 1'b1);
      acc(1'b0, 8'h08, 32'h0, 1'b0, B + 32'h2);
      tick(4);
      @(negedge clk);
      chk(evt, 1'b0);
      // Two events: one word fits, the other must wait for room
      push(2);
      @(negedge clk);
      chk({31'h0, sp_rd}, 32'h0);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h40);
      acc(1'b0, 8'h08, 32'h0, 1'b0, B + 32'h3);
      tick(2);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h40);
      acc(1'b1, 8'h00, 32'h0000_4001, 1'b0, 32'h0);
      acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h0);
      acc(1'b0, 8'h08, 32'h0, 1'b1, 32'h0);
      acc(1'b1, 8'h00, 32'h0001_4001, 1'b1, 32'h0);
      acc(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0);
      acc(1'b1, 8'h04, 32'h1, 1'b1, 32'h0);
      end_of_test();
   end
endmodule
